// *** hw/prd_defines.svh ***
// Purpose: Register offsets, field positions, reset values and scaling constants
// Assumes: Included by bare name from every design file but the package
// Notes: Inputs arrive in tenths of kPa and tenths of degC, so gains are scaled by 1/10
`ifndef PRD_DEFINES_SVH
`define PRD_DEFINES_SVH

// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define PRD_ADDR_W 8
`define PRD_REG_CTRL 8'h00
`define PRD_REG_STATUS 8'h04
`define PRD_REG_PRESS 8'h08
`define PRD_REG_TEMP 8'h0c
`define PRD_REG_DEBOUNCE 8'h10
`define PRD_CTRL_SLEEP 0
`define PRD_DEBOUNCE_RST 16'h0010
`define PRD_SYNC_RST 4'h1
`define PRD_RESP_OKAY 2'h0
`define PRD_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// Transfer functions
// ------------------------------------------------------------
`define PRD_P_GAIN 32'sh00000016
`define PRD_P_OFFSET (-32'sh00002260)
`define PRD_T_GAIN 32'sh0000000f
`define PRD_T_OFFSET 32'sh00001d4c
`define PRD_WORD_MAX 32'sh00007fff
`define PRD_WORD_MIN (-32'sh00008000)

// ------------------------------------------------------------
// Configuration memory check
// ------------------------------------------------------------
`define PRD_NVM_AW 4
`define PRD_NVM_LAST 4'hf
`define PRD_CSUM_GOOD 16'h0000

`endif

// *** hw/prd_pkg.sv ***
// Purpose: Shared types of the pressure readout core
// Assumes: prd_defines.svh supplies numeric constants
// Notes: Status bits travel together as one packed struct
package prd_pkg;

  // ------------------------------------------------------------
  // Operating states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PRD_CHECK,
    PRD_RUN,
    PRD_SLEEP,
    PRD_FAIL
  } prd_state_t;

  // ------------------------------------------------------------
  // Status word, bit 6 first
  // ------------------------------------------------------------
  typedef struct packed {
    logic check_done;
    logic asleep;
    logic csum_fail;
    logic bridge_supply_fault_flag;
    logic bridge_check_fault_flag;
    logic t_updated;
    logic p_updated;
  } prd_status_t;

endpackage

// *** hw/prd_debounce.sv ***
// Purpose: Debounce filter for the combined bridge comparator fault
// Assumes: Input already synchronised to mclk
// Notes: A threshold of zero behaves like one
`timescale 1ns/100ps
`include "prd_defines.svh"
module prd_debounce
  import prd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fault_raw,
  input wire logic [15:0] threshold,
  output logic fault_stable
);

  logic [15:0] run_cnt;

  // ------------------------------------------------------------
  // Count consecutive fault cycles; any clean cycle restarts
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      run_cnt <= 16'h0000;
    else if (!fault_raw)
      run_cnt <= 16'h0000;
    else if (run_cnt != 16'hffff)
      run_cnt <= run_cnt + 16'h0001; // Saturate so a long fault never wraps
  end

  // Level is high while the run has reached the threshold
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      fault_stable <= 1'b0;
    else
      fault_stable <= fault_raw && ({1'b0, run_cnt} + 17'h00001 >= {1'b0, threshold});
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_debounce_run: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(fault_stable) |-> $past(fault_raw)
    && ({1'b0, $past(run_cnt)} + 17'h00001 >= {1'b0, $past(threshold)}))
    else $error("debounce released before threshold");

  a_debounce_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    !fault_raw |=> !fault_stable)
    else $error("debounce held without fault");

endmodule

// *** hw/prd_readout.sv ***
// Purpose: Pressure and temperature readout, diagnostics, sleep and memory check
// Assumes: Samples and memory data on mclk; comparators and scl are asynchronous
// Notes: AXI4-Lite slave, one write and one read in flight at most
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "prd_defines.svh"
module prd_readout
  import prd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [`PRD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PRD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] press_dkpa,
  input wire logic press_valid,
  input wire logic [15:0] temp_ddegc,
  input wire logic temp_valid,
  input wire logic scl_pin,
  input wire logic bridge_win_p_a,
  input wire logic bridge_win_n_a,
  input wire logic bridge_supply_bad_a,
  output logic [`PRD_NVM_AW-1:0] nvm_addr,
  input wire logic [15:0] nvm_rdata
);

  // ------------------------------------------------------------
  // Scaling with saturation to a 16-bit two's-complement word
  // ------------------------------------------------------------
  function automatic logic [15:0] prd_scale(input logic [15:0] x, input logic signed [31:0] gain,
                                            input logic signed [31:0] off);
    logic signed [31:0] acc;
    acc = 32'(signed'(x)) * gain + off;
    if (acc > `PRD_WORD_MAX)
      prd_scale = 16'h7fff;
    else if (acc < `PRD_WORD_MIN)
      prd_scale = 16'h8000;
    else
      prd_scale = acc[15:0];
  endfunction

  prd_state_t state;
  prd_status_t status;
  logic [15:0] p_word;
  logic [15:0] t_word;
  logic [15:0] debounce_thr;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic scl_prev;
  logic scl_rise;
  logic bc_stable;
  logic rd_vld;
  logic rd_last;
  logic [15:0] csum;
  logic [`PRD_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic sleep_cmd;
  logic rd_press;
  logic rd_temp;
  logic acquire;

  // ------------------------------------------------------------
  // Pin synchronisers: scl and the three comparator outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_a <= `PRD_SYNC_RST;
      sync_b <= `PRD_SYNC_RST;
      scl_prev <= 1'b1; // Scl idles high, so no false wake edge after reset
    end
    else
    begin
      sync_a <= {bridge_supply_bad_a, bridge_win_n_a, bridge_win_p_a, scl_pin};
      sync_b <= sync_a;
      scl_prev <= sync_b[0];
    end
  end
  // Each pin gets its own two stages; the window OR only sees settled levels
  assign scl_rise = sync_b[0] && !scl_prev;

  // Combined window fault is filtered before it may set the flag
  prd_debounce u_debounce (
    .mclk(mclk),
    .rst_b(rst_b),
    .fault_raw(sync_b[1] | sync_b[2]),
    .threshold(debounce_thr),
    .fault_stable(bc_stable)
  );

  // ------------------------------------------------------------
  // Power-up memory check: one word a cycle, data one cycle late
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nvm_addr <= '0;
      rd_vld <= 1'b0;
      rd_last <= 1'b0;
      csum <= 16'h0000;
    end
    else if (state == PRD_CHECK)
    begin
      rd_vld <= !rd_last;
      rd_last <= (nvm_addr == `PRD_NVM_LAST) && !rd_last;
      if (nvm_addr != `PRD_NVM_LAST)
        nvm_addr <= nvm_addr + 1'b1;
      if (rd_vld)
        csum <= csum + nvm_rdata;
    end
    else
    begin
      rd_vld <= 1'b0;
      rd_last <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Operating state
  // ------------------------------------------------------------
  assign sleep_cmd = wr_fire && aw_addr == `PRD_REG_CTRL && w_strb[0]
                     && w_data[`PRD_CTRL_SLEEP];
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      state <= PRD_CHECK;
    else
      unique case (state)
        PRD_CHECK:
          if (rd_last)
            state <= (csum + nvm_rdata == `PRD_CSUM_GOOD) ? PRD_RUN : PRD_FAIL;
        PRD_RUN:
          if (sleep_cmd)
            state <= PRD_SLEEP;
        PRD_SLEEP:
          if (scl_rise)
            state <= PRD_RUN;
        PRD_FAIL:
          state <= PRD_FAIL; // Idle for good; only a reset retries the check
      endcase
  end

  // ------------------------------------------------------------
  // Result words: written only while running
  // ------------------------------------------------------------
  assign acquire = state == PRD_RUN;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      p_word <= 16'h0000;
      t_word <= 16'h0000;
    end
    else
    begin
      if (acquire && press_valid)
        p_word <= prd_scale(press_dkpa, `PRD_P_GAIN, `PRD_P_OFFSET);
      if (acquire && temp_valid)
        t_word <= prd_scale(temp_ddegc, `PRD_T_GAIN, `PRD_T_OFFSET);
    end
  end

  // ------------------------------------------------------------
  // Status flags; a new event beats a clear by read
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      status <= '0;
    else
    begin
      if (acquire && press_valid)
        status.p_updated <= 1'b1;
      else if (rd_press)
        status.p_updated <= 1'b0;
      if (acquire && temp_valid)
        status.t_updated <= 1'b1;
      else if (rd_temp)
        status.t_updated <= 1'b0;
      // Fault flags are sticky so a short fault is still seen
      if (bc_stable)
        status.bridge_check_fault_flag <= 1'b1;
      if (sync_b[3])
        status.bridge_supply_fault_flag <= 1'b1;
      status.csum_fail <= state == PRD_FAIL;
      status.asleep <= state == PRD_SLEEP;
      status.check_done <= state != PRD_CHECK;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channel: address and data in either order
  // ------------------------------------------------------------
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PRD_RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `PRD_REG_CTRL || aw_addr == `PRD_REG_DEBOUNCE
                        || aw_addr == `PRD_REG_STATUS || aw_addr == `PRD_REG_PRESS
                        || aw_addr == `PRD_REG_TEMP) ? `PRD_RESP_OKAY : `PRD_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Debounce threshold, written through its low byte lanes
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      debounce_thr <= `PRD_DEBOUNCE_RST;
    else if (wr_fire && aw_addr == `PRD_REG_DEBOUNCE)
    begin
      if (w_strb[0])
        debounce_thr[7:0] <= w_data[7:0];
      if (w_strb[1])
        debounce_thr[15:8] <= w_data[15:8];
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel: data one cycle after the address
  // ------------------------------------------------------------
  assign rd_press = s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRD_REG_PRESS;
  assign rd_temp = s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRD_REG_TEMP;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PRD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PRD_RESP_OKAY;
      unique case (s_axi_araddr)
        `PRD_REG_CTRL: s_axi_rdata <= {31'h00000000, state == PRD_SLEEP};
        `PRD_REG_STATUS: s_axi_rdata <= {25'h0000000, status};
        `PRD_REG_PRESS: s_axi_rdata <= {16'h0000, p_word};
        `PRD_REG_TEMP: s_axi_rdata <= {16'h0000, t_word};
        `PRD_REG_DEBOUNCE: s_axi_rdata <= {16'h0000, debounce_thr};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PRD_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_press_transfer: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_RUN && press_valid)
    |=> p_word == prd_scale($past(press_dkpa), `PRD_P_GAIN, `PRD_P_OFFSET))
    else $error("pressure word mismatch");

  a_press_ceiling: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_RUN && press_valid && !press_dkpa[15] && press_dkpa >= 16'h1800)
    |=> p_word == 16'h7fff)
    else $error("pressure not clamped at ceiling");

  a_press_under: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_RUN && press_valid && $signed(press_dkpa) < $signed(16'h0190))
    |=> p_word[15])
    else $error("under-pressure not negative");

  a_temp_transfer: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_RUN && temp_valid)
    |=> t_word == prd_scale($past(temp_ddegc), `PRD_T_GAIN, `PRD_T_OFFSET))
    else $error("temperature word mismatch");

  a_temp_under: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_RUN && temp_valid && $signed(temp_ddegc) < $signed(16'hfe0c))
    |=> t_word[15])
    else $error("under-temperature not negative");

  a_sleep_frozen: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_SLEEP) |=> $stable(p_word) && $stable(t_word))
    else $error("sample taken while asleep");

  a_wake_edge: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_SLEEP && scl_rise) |=> state == PRD_RUN)
    else $error("no wake on scl rise");

  a_bridge_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
    status.bridge_check_fault_flag |=> status.bridge_check_fault_flag)
    else $error("bridge fault flag dropped");

  a_supply_set: assert property (@(posedge mclk) disable iff (!rst_b)
    sync_b[3] |=> status.bridge_supply_fault_flag ##1 status.bridge_supply_fault_flag)
    else $error("supply fault not latched");

  a_csum_block: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PRD_FAIL) |=> $stable(p_word) && !$rose(status.p_updated)
    && !$rose(status.t_updated))
    else $error("results written after checksum failure");

  a_status_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRD_REG_STATUS)
    |=> s_axi_rvalid && s_axi_rdata[3:2] == $past({status.bridge_supply_fault_flag,
                                                   status.bridge_check_fault_flag}))
    else $error("status read lost fault flags");

  c_sleep_wake: cover property (@(posedge mclk) disable iff (!rst_b)
    state == PRD_SLEEP ##1 state == PRD_RUN);
  c_csum_fail: cover property (@(posedge mclk) disable iff (!rst_b)
    state == PRD_CHECK ##1 state == PRD_FAIL);
  c_bridge_fault: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(status.bridge_check_fault_flag));
  c_under_press: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(p_word[15]));

endmodule

// *** verification/prd_host_model.sv ***
// Purpose: Far-side stand-in: configuration memory and serial clock master
// Assumes: Memory read is synchronous with one cycle of latency
// Notes: Serial clock idles high as on a pulled-up bus and toggles only on request
`timescale 1ns/100ps
`include "prd_defines.svh"
module prd_host_model
(
  input wire logic mclk,
  input wire logic spoil,
  input wire logic wake_req,
  input wire logic [`PRD_NVM_AW-1:0] nvm_addr,
  output logic [15:0] nvm_rdata,
  output logic scl_pin
);
  logic [15:0] mem [16];
  logic [15:0] sum;

  // Last word balances the additive sum to zero
  initial
  begin
    scl_pin = 1'b1;
    sum = 16'h0000;
    for (int i = 0; i < 15; i++)
    begin
      mem[i] = 16'(i * 16'h1357 + 16'h00a5);
      sum = sum + mem[i];
    end
    mem[15] = 16'h0000 - sum;
  end

  // Spoiling adds one per word, so the sum misses by sixteen
  always_ff @(posedge mclk)
    nvm_rdata <= mem[nvm_addr] + {15'h0000, spoil};

  // Two rising edges at a 160 ns period, then back to idle high;
  // the 3 ns lead keeps every pin change clear of an mclk edge
  always @(posedge wake_req)
  begin
    #3 scl_pin = 1'b0;
    #80 scl_pin = 1'b1;
    #80 scl_pin = 1'b0;
    #80 scl_pin = 1'b1;
  end
endmodule

// *** verification/pressure_sensor_readout_diag_tb.sv ***
// Purpose: Self-checking bench for the readout core against an integer model
// Assumes: AXI4-Lite master drives right after rising edges
// Notes: Debounce lowered to 4 so short glitches and real faults are both cheap
`timescale 1ns/100ps
`include "prd_defines.svh"
module pressure_sensor_readout_diag_tb;
  import prd_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  logic [15:0] press_dkpa = 16'h0, temp_ddegc = 16'h0, nvm_rdata;
  logic press_valid = 1'b0, temp_valid = 1'b0, scl_pin, spoil = 1'b0, wake_req = 1'b0;
  logic win_p = 1'b0, win_n = 1'b0, sup_bad = 1'b0;
  logic [3:0] nvm_addr;
  int failures = 0;
  int n_compared = 0;
  bit m_p, m_t, m_bc, m_bs, m_cf, m_sl;
  logic [31:0] m_pw = 32'h0, m_tw = 32'h0;
  int pv[8] = '{400, 1800, 399, 0, 1889, 1890, -32768, 32767};
  int tv[6] = '{-500, 1500, -501, 1684, 1685, -32768};

  always #5 mclk = ~mclk;

  prd_readout prd_readout_i (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .press_dkpa(press_dkpa), .press_valid(press_valid),
    .temp_ddegc(temp_ddegc), .temp_valid(temp_valid), .scl_pin(scl_pin),
    .bridge_win_p_a(win_p), .bridge_win_n_a(win_n), .bridge_supply_bad_a(sup_bad),
    .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata));

  prd_host_model prd_host_model_i (.mclk(mclk), .spoil(spoil), .wake_req(wake_req),
    .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .scl_pin(scl_pin));

  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s response: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // ------------------------------------------------------------
  // Bus cycles; a wait that overruns ends the run
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
    else
    begin
      r = bresp;
      bready <= 1'b0;
      @(posedge mclk); // Let an edge pass so a next call never re-drives bready at once
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
    else
    begin
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge mclk); // Let an edge pass so a next call never re-drives rready at once
    end
  endtask

  // ------------------------------------------------------------
  // Model
  // ------------------------------------------------------------
  function automatic logic [31:0] sat16(input int v);
    if (v > 32767)
      v = 32767;
    if (v < -32768)
      v = -32768;
    return {16'h0000, v[15:0]};
  endfunction

  function automatic logic [31:0] stat_exp();
    return {25'h0, 1'b1, m_sl, m_cf, m_bs, m_bc, m_t, m_p};
  endfunction

  task automatic chk_status();
    axi_rd(`PRD_REG_STATUS, got, resp);
    chk_word("status", stat_exp(), got);
  endtask

  // One sample, then status and result word; results move only while running
  task automatic meas(input bit is_t, input int v);
    if (is_t)
    begin
      temp_ddegc <= v[15:0];
      temp_valid <= 1'b1;
    end
    else
    begin
      press_dkpa <= v[15:0];
      press_valid <= 1'b1;
    end
    if (!m_sl && !m_cf && is_t)
      {m_t, m_tw} = {1'b1, sat16(15 * v + 7500)};
    if (!m_sl && !m_cf && !is_t)
      {m_p, m_pw} = {1'b1, sat16(22 * v - 8800)};
    @(posedge mclk);
    temp_valid <= 1'b0;
    press_valid <= 1'b0;
    @(posedge mclk);
    chk_status();
    axi_rd(is_t ? `PRD_REG_TEMP : `PRD_REG_PRESS, got, resp);
    chk_word(is_t ? "temp word" : "press word", is_t ? m_tw : m_pw, got);
    if (is_t)
      m_t = 0;
    else
      m_p = 0;
  endtask

  // Pin 0 window p, 1 window n, 2 supply, 3 wake request
  task automatic pulse(input int k, input int n);
    int i;
    for (i = 0; i < 2; i++)
    begin
      case (k)
        0: win_p <= (i == 0);
        1: win_n <= (i == 0);
        2: sup_bad <= (i == 0);
        default: wake_req <= (i == 0);
      endcase
      if (i == 0)
        repeat (n) @(posedge mclk);
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(52));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (30) @(posedge mclk);
    chk_status();
    axi_rd(`PRD_REG_DEBOUNCE, got, resp);
    chk_word("debounce reset", 32'h10, got);
    foreach (pv[i]) meas(0, pv[i]);
    foreach (tv[i]) meas(1, tv[i]);
    repeat (6)
    begin
      meas(0, int'($urandom_range(2200)) - 100);
      meas(1, int'($urandom_range(2200)) - 600);
    end
    // Short glitch is filtered, back-to-back comparators add up
    axi_wr(`PRD_REG_DEBOUNCE, 32'h4, resp);
    chk_resp("debounce write", `PRD_RESP_OKAY, resp);
    pulse(0, 2);
    repeat (10) @(posedge mclk);
    chk_status();
    pulse(0, 3);
    pulse(1, 3);
    repeat (10) @(posedge mclk);
    m_bc = 1;
    chk_status();
    pulse(2, 2);
    repeat (8) @(posedge mclk);
    m_bs = 1;
    chk_status();
    // Only byte lane 0 of the threshold may change
    wstrb <= 4'h1;
    axi_wr(`PRD_REG_DEBOUNCE, 32'hffff0007, resp);
    wstrb <= 4'hf;
    axi_rd(`PRD_REG_DEBOUNCE, got, resp);
    chk_word("debounce lane", 32'h7, got);
    // Unmapped place and read-only result
    axi_wr(8'h14, 32'h1, resp);
    chk_resp("unmapped write", `PRD_RESP_SLVERR, resp);
    axi_rd(8'h14, got, resp);
    chk_resp("unmapped read", `PRD_RESP_SLVERR, resp);
    chk_word("unmapped data", 32'h0, got);
    axi_wr(`PRD_REG_PRESS, 32'h1234, resp);
    chk_resp("press write", `PRD_RESP_OKAY, resp);
    meas(0, 1000);
    // Sleep stops sampling until the serial clock rises
    axi_wr(`PRD_REG_CTRL, 32'h1, resp);
    m_sl = 1;
    repeat (2) @(posedge mclk);
    axi_rd(`PRD_REG_CTRL, got, resp);
    chk_word("ctrl asleep", 32'h1, got);
    meas(0, 1500);
    pulse(3, 1);
    repeat (60) @(posedge mclk);
    m_sl = 0;
    axi_rd(`PRD_REG_CTRL, got, resp);
    chk_word("ctrl awake", 32'h0, got);
    meas(0, 1200);
    // Bad checksum leaves the core idle after the next reset
    spoil <= 1'b1;
    rst_b <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    {m_p, m_t, m_bc, m_bs, m_cf, m_pw, m_tw} = {5'b00001, 64'h0};
    repeat (30) @(posedge mclk);
    meas(0, 1000);
    meas(1, 300);
    wrap_up();
  end
endmodule
